// ---- hdl/addr_dec_pkg.sv ----
// Shared types and constants for the instruction fetch and addressing decoder.
// Assumes an 8-bit core with a 16-bit byte address space.
package addr_dec_pkg;
  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L, M_IND_S, M_IND_L,
    M_IIX_S, M_IIX_L, M_REL_D, M_REL_I, M_BIT_D, M_BIT_I, M_BREL_D, M_BREL_I
  } mode_t;
  typedef enum logic [3:0] {
    G_LOAD, G_STACK, G_INCDEC, G_CMP, G_LOGIC, G_BIT, G_BTJ, G_ARITH, G_SHIFT,
    G_JUMP, G_COND, G_INTR, G_FLAG
  } group_t;
  typedef enum logic [1:0] {PRE_NONE, PRE_Y, PRE_IND, PRE_IY} prefix_t;
  localparam logic [7:0] PREBYTE_Y = 8'h90;
  localparam logic [7:0] PREBYTE_IY = 8'h91;
  localparam logic [7:0] PREBYTE_IND = 8'h92;
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [15:0] SHORT_IDX_MAX = 16'h01fe;
  localparam logic [2:0] INSN_MAX_LEN = 3'h4;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [3:0] RELATIVE_SUBROUTINE_CALL_LO = 4'hd;
  // Row is the opcode high nibble, bit is the low nibble; a clear bit is an undefined code
  localparam logic [15:0] VALID_MASK [16] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hf7d9, 16'hf7dd, 16'hf7d9, 16'hf7d9, 16'hf7d9,
    16'hc77b, 16'hffff, 16'h6f7f, 16'hffff, 16'hcfff, 16'hcfff, 16'hffff, 16'hffff
  };
  function automatic logic [1:0] pc_bytes(input mode_t m);
    case (m)
      M_INH, M_IDX0: pc_bytes = 2'h0;
      M_DIR_L, M_IDX_L, M_BREL_D, M_BREL_I: pc_bytes = 2'h2;
      default: pc_bytes = 2'h1;
    endcase
  endfunction
  function automatic logic [1:0] ptr_bytes(input mode_t m);
    case (m)
      M_IND_L, M_IIX_L: ptr_bytes = 2'h2;
      M_IND_S, M_IIX_S, M_REL_I, M_BIT_I, M_BREL_I: ptr_bytes = 2'h1;
      default: ptr_bytes = 2'h0;
    endcase
  endfunction
endpackage

// ---- hdl/op_classifier.sv ----
// Opcode classifier: addressing mode, group, legality and prebyte pairing.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/100ps
`default_nettype none
module op_classifier (
  input wire logic [7:0] i_opcode,
  input wire addr_dec_pkg::prefix_t i_prefix,
  output var addr_dec_pkg::mode_t o_mode,
  output var addr_dec_pkg::group_t o_group,
  output var addr_dec_pkg::prefix_t o_prefix,
  output var logic o_legal,
  output var logic o_is_prebyte,
  output var logic o_pair_ok,
  output var logic o_use_y
);
  import addr_dec_pkg::*;
  logic [3:0] hi;
  logic [3:0] lo;
  mode_t base;
  assign hi = i_opcode[7:4];
  assign lo = i_opcode[3:0];
  assign o_legal = VALID_MASK[hi][lo];
  assign o_is_prebyte = (i_opcode == PREBYTE_Y) || (i_opcode == PREBYTE_IY) || (i_opcode == PREBYTE_IND);
  assign o_prefix = (i_opcode == PREBYTE_Y) ? PRE_Y : (i_opcode == PREBYTE_IY) ? PRE_IY : PRE_IND;
  always_comb begin
    case (hi)
      4'h0: base = M_BREL_D;
      4'h1: base = M_BIT_D;
      4'h2: base = M_REL_D;
      4'h3, 4'hb: base = M_DIR_S;
      4'h6, 4'he: base = M_IDX_S;
      4'h7, 4'hf: base = M_IDX0;
      4'ha: base = (lo == RELATIVE_SUBROUTINE_CALL_LO) ? M_REL_D : M_IMM;
      4'hc: base = M_DIR_L;
      4'hd: base = M_IDX_L;
      default: base = M_INH;
    endcase
  end
  always_comb begin
    o_mode = base;
    o_use_y = 1'b0;
    o_pair_ok = 1'b1;
    case (i_prefix)
      PRE_Y: begin
        o_pair_ok = base inside {M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L}; // RL20
        o_use_y = o_pair_ok;
      end
      PRE_IND: begin
        case (base) // RL21
          M_DIR_S: o_mode = M_IND_S;
          M_DIR_L: o_mode = M_IND_L;
          M_BIT_D: o_mode = M_BIT_I;
          M_BREL_D: o_mode = M_BREL_I;
          M_REL_D: o_mode = M_REL_I;
          M_IDX_S: o_mode = M_IIX_S;
          M_IDX_L: o_mode = M_IIX_L;
          default: o_pair_ok = 1'b0;
        endcase
      end
      PRE_IY: begin
        o_use_y = 1'b1; // RL22
        case (base)
          M_IDX_S: o_mode = M_IIX_S;
          M_IDX_L: o_mode = M_IIX_L;
          default: begin
            o_pair_ok = 1'b0;
            o_use_y = 1'b0;
          end
        endcase
      end
      default: ;
    endcase
  end
  always_comb begin
    case (hi) // RL18
      4'h0: o_group = G_BTJ;
      4'h1: o_group = G_BIT;
      4'h2: o_group = (lo < 4'h2) ? G_JUMP : G_COND;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        case (lo)
          4'h0, 4'h3: o_group = G_LOGIC;
          4'ha, 4'hc: o_group = G_INCDEC;
          4'hd: o_group = G_CMP;
          4'hf: o_group = G_LOAD;
          4'h2: o_group = G_ARITH;
          default: o_group = G_SHIFT;
        endcase
      end
      4'h8: o_group = (lo inside {4'h0, 4'h3, 4'he, 4'hf}) ? G_INTR : (lo == 4'h1) ? G_JUMP : G_STACK;
      4'h9: o_group = (lo inside {[4'h8:4'hb]}) ? G_FLAG : (lo == 4'hc) ? G_STACK :
                      (lo == 4'hd) ? G_JUMP : G_LOAD;
      default: begin
        case (lo)
          4'h0, 4'h2, 4'h9, 4'hb: o_group = G_ARITH;
          4'h1, 4'h3, 4'h5: o_group = G_CMP;
          4'h4, 4'h8, 4'ha: o_group = G_LOGIC;
          4'hc, 4'hd: o_group = G_JUMP;
          default: o_group = G_LOAD;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- hdl/ea_adder.sv ----
// Effective address and relative target arithmetic for every addressing mode.
// Combinational; inputs are the bytes already gathered by the fetch sequencer.
`timescale 1ns/100ps
`default_nettype none
module ea_adder (
  input wire addr_dec_pkg::mode_t i_mode,
  input wire logic [7:0] i_byte1,
  input wire logic [7:0] i_byte2,
  input wire logic [7:0] i_ptr_hi,
  input wire logic [7:0] i_ptr_lo,
  input wire logic [7:0] i_index,
  input wire logic [15:0] i_pc_next,
  output var logic [15:0] o_ea,
  output var logic [15:0] o_target,
  output var logic [7:0] o_operand
);
  import addr_dec_pkg::*;
  logic [7:0] off;
  logic [15:0] idx16;
  logic [15:0] ptr16;
  assign idx16 = {PAGE0_HI, i_index};
  assign ptr16 = {i_ptr_hi, i_ptr_lo};
  always_comb begin
    off = i_byte1;
    o_operand = 8'h00;
    o_ea = {PAGE0_HI, i_byte1}; // RL3
    case (i_mode)
      M_IMM: o_operand = i_byte1; // RL2
      M_DIR_L: o_ea = {i_byte1, i_byte2}; // RL4
      M_IDX0: o_ea = idx16; // RL6
      M_IDX_S: o_ea = idx16 + {PAGE0_HI, i_byte1}; // RL5 RL7
      M_IDX_L: o_ea = idx16 + {i_byte1, i_byte2}; // RL8
      M_IND_S, M_BIT_I: o_ea = {PAGE0_HI, i_ptr_lo}; // RL9
      M_IND_L: o_ea = ptr16; // RL9
      M_IIX_S: o_ea = idx16 + {PAGE0_HI, i_ptr_lo}; // RL10
      M_IIX_L: o_ea = idx16 + ptr16; // RL10
      M_REL_I: off = i_ptr_lo; // RL12
      M_BREL_D: off = i_byte2;
      M_BREL_I: begin
        off = i_byte2;
        o_ea = {PAGE0_HI, i_ptr_lo};
      end
      default: ;
    endcase
    // Offset is signed and counts from the byte after the instruction
    o_target = i_pc_next + {{8{off[7]}}, off}; // RL11 RL23
  end
endmodule
`default_nettype wire

// ---- hdl/insn_fetch_decoder.sv ----
// Instruction fetch sequencer and addressing-mode decoder for an 8-bit core.
// Assumes a byte-wide memory port that answers each held request with a one-cycle ack,
// and index registers held steady by the core while an instruction is decoded.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RL1: Inherent instructions are one opcode byte, no operand bytes fetched.
// RL2: Immediate instructions are opcode plus one operand value byte.
// RL3: Short direct fetches one address byte, range 00 to FF.
// RL4: Long direct fetches a two-byte address, full 64 Kbyte space.
// RL5: Indexed address is the unsigned sum of index register and offset.
// RL6: Indexed without offset fetches nothing and uses the index alone.
// RL7: Short indexed fetches one offset byte, range 00 to 1FE.
// RL8: Long indexed fetches a two-byte offset, full 64 Kbyte space.
// RL9: Indirect fetches a pointer address byte, then a byte or word pointer.
// RL10: Indirect indexed adds the index to a byte or word pointer.
// RL11: Relative adds a signed 8-bit offset to the program counter.
// RL12: Direct relative offset follows opcode; indirect reads it via an address.
// RL13: Only conditional jumps and relative call use relative modes.
// RL14: Inherent form accepted for the listed control, stack and register ops.
// RL15: Immediate form only for load, compare, bit compare, logic, add/subtract.
// RL16: ALU, load and compare ops have short and long memory forms.
// RL17: Read-modify-write, bit, call and jump ops have short forms only.
// RL18: Sixty-three instructions grouped into thirteen functional groups.
// RL19: An instruction is one to four bytes including optional prebyte.
// RL20: Prebyte 90 switches X based instructions to the second index.
// RL21: Prebyte 92 turns direct and X indexed forms into indirect forms.
// RL22: Prebyte 91 turns X indirect indexed into Y indirect indexed.
// RL23: Relative offsets count from the address after the instruction.
// RL24: An undefined opcode raises the illegal-code reset.
// RL25: A valid prebyte with an unpaired valid opcode raises no reset.
// RL26: Bytes are fetched in order from the program counter, which advances.
module insn_fetch_decoder (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  input wire logic i_next,
  input wire logic i_take_branch,
  input wire logic [7:0] i_x_index,
  input wire logic [7:0] i_y_index,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data,
  output var logic o_mem_req,
  output var logic [15:0] o_mem_addr,
  output var logic o_valid,
  output var logic [7:0] o_opcode,
  output var addr_dec_pkg::mode_t o_mode,
  output var addr_dec_pkg::group_t o_group,
  output var logic o_use_y,
  output var logic [15:0] o_ea,
  output var logic [7:0] o_operand,
  output var logic [15:0] o_rel_target,
  output var logic [15:0] o_pc,
  output var logic [2:0] o_len,
  output var logic o_illegal_rst,
  output var logic o_pair_ignored
);
  import addr_dec_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_B1, ST_B2, ST_PH, ST_PL, ST_CALC, ST_DONE} state_t;

  state_t state_r;
  state_t state_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic req_r;
  logic req_nxt;
  logic [7:0] opcode_r;
  logic [7:0] b1_r;
  logic [7:0] b2_r;
  logic [7:0] ph_r;
  logic [7:0] pl_r;
  logic [7:0] ptr_base;
  logic [7:0] idx_sel;
  prefix_t pre_r;
  mode_t mode_r;
  group_t group_r;
  logic use_y_r;
  logic pair_bad_r;
  logic valid_r;
  logic illegal_r;
  logic [2:0] len_r;
  logic [15:0] ea_r;
  logic [15:0] target_r;
  logic [7:0] operand_r;
  mode_t cls_mode;
  group_t cls_group;
  prefix_t cls_prefix;
  logic cls_legal;
  logic cls_pre;
  logic cls_pair_ok;
  logic cls_use_y;
  logic [15:0] ea_calc;
  logic [15:0] target_calc;
  logic [7:0] operand_calc;
  logic fetch_ack;
  logic op_taken;
  logic start;
  logic has_pre;
  logic is_rel;

  op_classifier u_cls (
    .i_opcode(i_mem_data),
    .i_prefix(pre_r),
    .o_mode(cls_mode),
    .o_group(cls_group),
    .o_prefix(cls_prefix),
    .o_legal(cls_legal),
    .o_is_prebyte(cls_pre),
    .o_pair_ok(cls_pair_ok),
    .o_use_y(cls_use_y)
  );

  // Index sampled only in the calculation cycle
  assign idx_sel = use_y_r ? i_y_index : i_x_index;

  ea_adder u_ea (
    .i_mode(mode_r),
    .i_byte1(b1_r),
    .i_byte2(b2_r),
    .i_ptr_hi(ph_r),
    .i_ptr_lo(pl_r),
    .i_index(idx_sel),
    .i_pc_next(pc_r),
    .o_ea(ea_calc),
    .o_target(target_calc),
    .o_operand(operand_calc)
  );

  assign fetch_ack = i_mem_ack && (state_r inside {ST_OP, ST_B1, ST_B2});
  assign op_taken = (state_r == ST_OP) && i_mem_ack && !cls_pre;
  assign start = ((state_r == ST_IDLE) && i_pc_load) || ((state_r == ST_DONE) && (i_pc_load || i_next));
  assign has_pre = (pre_r != PRE_NONE);
  assign is_rel = mode_r inside {M_REL_D, M_REL_I, M_BREL_D, M_BREL_I};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (i_pc_load) begin
          state_nxt = ST_OP;
        end
      end
      ST_OP: begin
        if (i_mem_ack) begin
          if (cls_pre) begin
            state_nxt = ST_OP;
          end else if (!cls_legal) begin
            state_nxt = ST_IDLE; // RL24
          end else if (pc_bytes(cls_mode) != 2'h0) begin
            state_nxt = ST_B1;
          end else begin
            state_nxt = ST_CALC; // RL1 RL6
          end
        end
      end
      ST_B1: begin
        if (i_mem_ack) begin
          if (pc_bytes(mode_r) == 2'h2) begin
            state_nxt = ST_B2; // RL4 RL8
          end else if (ptr_bytes(mode_r) != 2'h0) begin
            state_nxt = ST_PH; // RL9 RL10
          end else begin
            state_nxt = ST_CALC; // RL2 RL3 RL7
          end
        end
      end
      ST_B2: begin
        if (i_mem_ack) begin
          state_nxt = (ptr_bytes(mode_r) != 2'h0) ? ST_PH : ST_CALC;
        end
      end
      ST_PH: begin
        if (i_mem_ack) begin
          state_nxt = (ptr_bytes(mode_r) == 2'h2) ? ST_PL : ST_CALC; // RL9
        end
      end
      ST_PL: begin
        if (i_mem_ack) begin
          state_nxt = ST_CALC;
        end
      end
      ST_CALC: state_nxt = ST_DONE;
      ST_DONE: begin
        if (i_pc_load || i_next) begin
          state_nxt = ST_OP;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    pc_nxt = pc_r;
    if (i_pc_load && (state_r inside {ST_IDLE, ST_DONE})) begin
      pc_nxt = i_pc_value;
    end else if ((state_r == ST_DONE) && i_next && i_take_branch && is_rel) begin
      pc_nxt = target_r; // RL11 RL13
    end else if (fetch_ack) begin
      pc_nxt = pc_r + 16'h0001; // RL26
    end
  end

  // Pointer address is the byte that may be arriving right now
  assign ptr_base = (state_r == ST_B1) ? i_mem_data : b1_r;

  always_comb begin
    if (state_nxt == ST_PH) begin
      addr_nxt = {PAGE0_HI, ptr_base}; // RL9
    end else if (state_nxt == ST_PL) begin
      // Word pointer low byte wraps inside page zero
      addr_nxt = {PAGE0_HI, b1_r + 8'h01};
    end else begin
      addr_nxt = pc_nxt; // RL26
    end
    req_nxt = state_nxt inside {ST_OP, ST_B1, ST_B2, ST_PH, ST_PL};
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      pc_r <= RESET_PC;
      addr_r <= RESET_PC;
      req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      addr_r <= addr_nxt;
      req_r <= req_nxt;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      opcode_r <= 8'h00;
      pre_r <= PRE_NONE;
      mode_r <= M_INH;
      group_r <= G_JUMP;
      use_y_r <= 1'b0;
      pair_bad_r <= 1'b0;
      len_r <= 3'h0;
    end else if (start) begin
      pre_r <= PRE_NONE;
      pair_bad_r <= 1'b0;
      len_r <= 3'h0;
    end else begin
      if (fetch_ack) begin
        len_r <= len_r + 3'h1; // RL19
      end
      if ((state_r == ST_OP) && i_mem_ack) begin
        if (cls_pre) begin
          pre_r <= cls_prefix; // RL20 RL21 RL22
          if (has_pre) begin
            // A second prebyte restarts the instruction at itself
            pair_bad_r <= 1'b1;
            len_r <= 3'h1;
          end
        end else begin
          opcode_r <= i_mem_data;
          mode_r <= cls_mode; // RL13 RL14 RL15 RL16 RL17
          group_r <= cls_group; // RL18
          use_y_r <= cls_use_y;
          if (!cls_pair_ok) begin
            pair_bad_r <= 1'b1; // RL25
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      ph_r <= 8'h00;
      pl_r <= 8'h00;
    end else if (i_mem_ack) begin
      case (state_r)
        ST_B1: b1_r <= i_mem_data; // RL12
        ST_B2: b2_r <= i_mem_data;
        ST_PH: begin
          if (ptr_bytes(mode_r) == 2'h2) begin
            ph_r <= i_mem_data;
          end else begin
            pl_r <= i_mem_data;
          end
        end
        ST_PL: pl_r <= i_mem_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_r <= 1'b0;
      ea_r <= 16'h0000;
      target_r <= 16'h0000;
      operand_r <= 8'h00;
    end else if (state_r == ST_CALC) begin
      valid_r <= 1'b1;
      ea_r <= ea_calc; // RL5
      target_r <= target_calc; // RL23
      operand_r <= operand_calc;
    end else if (start) begin
      valid_r <= 1'b0;
    end
  end

  // Undefined codes only; an unpaired prebyte and opcode decode without the prebyte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= op_taken && !cls_legal; // RL24 RL25
    end
  end

  assign o_mem_req = req_r;
  assign o_mem_addr = addr_r;
  assign o_valid = valid_r;
  assign o_opcode = opcode_r;
  assign o_mode = mode_r;
  assign o_group = group_r;
  assign o_use_y = use_y_r;
  assign o_ea = ea_r;
  assign o_operand = operand_r;
  assign o_rel_target = target_r;
  assign o_pc = pc_r;
  assign o_len = len_r;
  assign o_illegal_rst = illegal_r;
  assign o_pair_ignored = pair_bad_r;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence bad_op_s;
    (state_r == ST_OP) && i_mem_ack && !cls_pre && !cls_legal;
  endsequence
  sequence reset_pulse_s;
    (o_illegal_rst && state_r == ST_IDLE && !o_mem_req) ##1 !o_illegal_rst;
  endsequence
  sequence word_ptr_s;
    (state_r == ST_B1) && i_mem_ack && (ptr_bytes(mode_r) == 2'h2);
  endsequence

  inh_len_a: assert property ($rose(o_valid) && o_mode == M_INH |-> o_len == 3'h1 + {2'h0, has_pre}) // RL1
    else $error("inherent length wrong");
  imm_len_a: assert property ($rose(o_valid) && o_mode == M_IMM |->
    o_len == 3'h2 + {2'h0, has_pre} && o_operand == b1_r) // RL2
    else $error("immediate length or operand wrong");
  dir_page_a: assert property ($rose(o_valid) && o_mode == M_DIR_S |-> o_ea == {8'h00, b1_r}) // RL3
    else $error("short direct address wrong");
  dir_long_a: assert property ($rose(o_valid) && o_mode == M_DIR_L |->
    o_ea == {b1_r, b2_r} && o_len == 3'h3 + {2'h0, has_pre}) // RL4
    else $error("long direct address wrong");
  idx_sum_a: assert property ($rose(o_valid) && o_mode == M_IDX_S |->
    o_ea == ({8'h00, $past(idx_sel)} + {8'h00, b1_r}) && o_ea <= SHORT_IDX_MAX) // RL7
    else $error("short indexed address wrong");
  idx_none_a: assert property ($rose(o_valid) && o_mode == M_IDX0 |->
    o_ea[15:8] == 8'h00 && o_len == 3'h1 + {2'h0, has_pre}) // RL6
    else $error("no-offset indexed wrong");
  word_ptr_a: assert property (word_ptr_s |=> o_mem_req && o_mem_addr == {8'h00, $past(i_mem_data)}) // RL9
    else $error("pointer fetch address wrong");
  rel_target_a: assert property ($rose(o_valid) && o_mode == M_REL_D |->
    o_rel_target == o_pc + {{8{b1_r[7]}}, b1_r}) // RL23
    else $error("relative target wrong");
  illegal_code_a: assert property (bad_op_s |=> reset_pulse_s) // RL24
    else $error("illegal code not reset");
  pair_keep_a: assert property (op_taken && cls_legal |=> !o_illegal_rst) // RL25
    else $error("legal pair raised reset");
  pc_step_a: assert property (fetch_ack |=> o_pc == $past(o_pc) + 16'h0001) // RL26
    else $error("program counter did not advance");
  insn_len_a: assert property (o_valid |-> o_len >= 3'h1 && o_len <= INSN_MAX_LEN) // RL19
    else $error("instruction length out of range");
endmodule
`default_nettype wire

// ---- sim/mem_model.sv ----
// Byte-wide program and data memory standing on the far side of the fetch decoder.
// Assumes one request at a time, held until acknowledged; latency is set by the bench.
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  output var logic o_ack,
  output var logic [7:0] o_data
);
  logic [7:0] mem [65536];
  int delay;
  int cnt;
  // Data is inverted outside the ack cycle so a stale byte is never mistaken for a fresh one
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_data <= 8'h00;
      cnt <= 0;
    end else if (i_req && !o_ack && cnt >= delay) begin
      o_ack <= 1'b1;
      o_data <= mem[i_addr];
      cnt <= 0;
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      cnt <= (i_req && !o_ack) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the instruction fetch decoder.
// Assumes the memory partner in mem_model and the decoder's package constants.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import addr_dec_pkg::*;
  typedef struct {mode_t m; logic [15:0] ea; logic [15:0] aux; logic [2:0] len;
    logic [15:0] pc; logic y; logic ill; logic pi;} exp_t;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_pc_load = 1'b0;
  logic [15:0] i_pc_value = 16'h0000;
  logic i_next = 1'b0;
  logic i_take_branch = 1'b0;
  logic [7:0] i_x_index = 8'h00;
  logic [7:0] i_y_index = 8'h00;
  logic i_mem_ack;
  logic [7:0] i_mem_data;
  logic o_mem_req, o_valid, o_use_y, o_illegal_rst, o_pair_ignored;
  logic [15:0] o_mem_addr, o_ea, o_rel_target, o_pc;
  logic [7:0] o_operand;
  logic [7:0] o_opcode;
  group_t o_group;
  logic [2:0] o_len;
  mode_t o_mode;
  exp_t q [$];
  exp_t e;
  int failures = 0;
  int checked = 0;
  logic seen = 1'b0;
  logic [31:0] seed = 32'hd26c_db2e;
  logic [31:0] r;
  logic [7:0] x, off, hi;
  always #12.5 i_core_clk = ~i_core_clk;
  insn_fetch_decoder DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_pc_load(i_pc_load),
    .i_pc_value(i_pc_value), .i_next(i_next), .i_take_branch(i_take_branch), .i_x_index(i_x_index),
    .i_y_index(i_y_index), .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .o_valid(o_valid), .o_opcode(o_opcode), .o_mode(o_mode), .o_group(o_group),
    .o_use_y(o_use_y), .o_ea(o_ea), .o_operand(o_operand), .o_rel_target(o_rel_target), .o_pc(o_pc),
    .o_len(o_len), .o_illegal_rst(o_illegal_rst), .o_pair_ignored(o_pair_ignored));
  mem_model mem_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .o_ack(i_mem_ack), .o_data(i_mem_data));
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b [$]);
    logic [15:0] idx;
    foreach (b[i]) begin
      idx = a + 16'(i);
      mem_i.mem[idx] = b[i];
    end
  endtask
  task automatic ex(input mode_t m, input logic [15:0] ea, input logic [15:0] aux, input logic [2:0] len,
    input logic [15:0] pc, input logic y, input logic ill, input logic pi);
    exp_t t;
    t = '{m, ea, aux, len, pc, y, ill, pi};
    q.push_back(t);
  endtask
  // A hung fetch counts as a mismatch and closes the run
  task automatic wait_res();
    int n;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_valid !== 1'b1 && o_illegal_rst !== 1'b1 && n < 200);
    if (n >= 200) begin
      failures++;
      $display("[FAIL] completion expected 1 seen 0");
      final_report();
    end
  endtask
  task automatic go(input logic [15:0] a);
    @(negedge i_core_clk);
    i_pc_load = 1'b1;
    i_pc_value = a;
    @(negedge i_core_clk);
    i_pc_load = 1'b0;
    wait_res();
    $display("test at %h done", a);
  endtask
  // Watcher: takes the oldest note whenever a decode result or illegal-code pulse appears
  always @(negedge i_core_clk) begin
    if (!i_rst && (o_illegal_rst === 1'b1 || (o_valid === 1'b1 && !seen))) begin
      if (q.size() == 0) begin
        failures++;
        $display("[FAIL] result expected none seen one");
      end else begin
        e = q.pop_front();
        chk("illegal", e.ill, o_illegal_rst);
        if (!e.ill) begin
          chk("mode", e.m, o_mode);
          if (!(e.m inside {M_INH, M_IMM, M_REL_D, M_REL_I})) chk("ea", e.ea, o_ea);
          chk("aux", e.aux, (e.m inside {M_REL_D, M_REL_I, M_BREL_D, M_BREL_I}) ? o_rel_target :
            {8'h00, o_operand});
          chk("len", e.len, o_len);
          chk("pc", e.pc, o_pc);
          chk("use_y", e.y, o_use_y);
          chk("pair_ignored", e.pi, o_pair_ignored);
        end
      end
    end
    seen = (o_valid === 1'b1);
  end
  initial begin
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    put(16'h1000, '{8'h40});
    ex(M_INH, 0, 0, 1, 16'h1001, 0, 0, 0);
    go(16'h1000);
    put(16'h1010, '{8'ha6, 8'h55});
    ex(M_IMM, 0, 16'h0055, 2, 16'h1012, 0, 0, 0);
    go(16'h1010);
    put(16'h1020, '{8'hb6, 8'hc3});
    ex(M_DIR_S, 16'h00c3, 0, 2, 16'h1022, 0, 0, 0);
    go(16'h1020);
    put(16'h1030, '{8'hc6, 8'hab, 8'hcd});
    ex(M_DIR_L, 16'habcd, 0, 3, 16'h1033, 0, 0, 0);
    go(16'h1030);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      x = (k == 0) ? 8'hff : r[7:0];
      off = (k == 0) ? 8'hff : r[15:8];
      hi = r[23:16];
      mem_i.delay = k;
      i_x_index = x;
      put(16'h1100 + 16'(k * 16), '{8'he6, off});
      ex(M_IDX_S, {8'h00, x} + {8'h00, off}, 0, 2, 16'h1102 + 16'(k * 16), 0, 0, 0);
      go(16'h1100 + 16'(k * 16));
      put(16'h1104 + 16'(k * 16), '{8'hf6});
      ex(M_IDX0, {8'h00, x}, 0, 1, 16'h1105 + 16'(k * 16), 0, 0, 0);
      go(16'h1104 + 16'(k * 16));
      put(16'h1108 + 16'(k * 16), '{8'hd6, hi, off});
      ex(M_IDX_L, {hi, off} + {8'h00, x}, 0, 3, 16'h110b + 16'(k * 16), 0, 0, 0);
      go(16'h1108 + 16'(k * 16));
    end
    put(16'h0040, '{8'h12, 8'h34});
    put(16'h1200, '{8'h92, 8'hb6, 8'h40});
    ex(M_IND_S, 16'h0012, 0, 3, 16'h1203, 0, 0, 0);
    go(16'h1200);
    put(16'h1210, '{8'h92, 8'hc6, 8'h40});
    ex(M_IND_L, 16'h1234, 0, 3, 16'h1213, 0, 0, 0);
    go(16'h1210);
    i_x_index = 8'hf0;
    i_y_index = 8'h21;
    put(16'h1220, '{8'h92, 8'he6, 8'h40});
    ex(M_IIX_S, 16'h0102, 0, 3, 16'h1223, 0, 0, 0);
    go(16'h1220);
    put(16'h1230, '{8'h92, 8'hd6, 8'h40});
    ex(M_IIX_L, 16'h1324, 0, 3, 16'h1233, 0, 0, 0);
    go(16'h1230);
    put(16'h1240, '{8'h91, 8'he6, 8'h40});
    ex(M_IIX_S, 16'h0033, 0, 3, 16'h1243, 1, 0, 0);
    go(16'h1240);
    put(16'h1250, '{8'h90, 8'hf6});
    ex(M_IDX0, 16'h0021, 0, 2, 16'h1252, 1, 0, 0);
    go(16'h1250);
    put(16'h1258, '{8'h90, 8'ha6, 8'h77});
    ex(M_IMM, 0, 16'h0077, 3, 16'h125b, 1, 0, 0);
    go(16'h1258);
    put(16'h1300, '{8'h27, 8'hf0});
    put(16'h12f2, '{8'h40});
    ex(M_REL_D, 0, 16'h12f2, 2, 16'h1302, 0, 0, 0);
    go(16'h1300);
    chk("opcode", 16'h0027, {8'h00, o_opcode});
    chk("group", 16'(G_COND), 16'(o_group));
    ex(M_INH, 0, 0, 1, 16'h12f3, 0, 0, 0);
    @(negedge i_core_clk);
    i_next = 1'b1;
    i_take_branch = 1'b1;
    @(negedge i_core_clk);
    i_next = 1'b0;
    i_take_branch = 1'b0;
    chk("branch_addr", 16'h12f2, o_mem_addr);
    wait_res();
    $display("branch test done");
    put(16'h1310, '{8'h92, 8'h27, 8'h40});
    ex(M_REL_I, 0, 16'h1325, 3, 16'h1313, 0, 0, 0);
    go(16'h1310);
    put(16'h1320, '{8'had, 8'h7f});
    ex(M_REL_D, 0, 16'h13a1, 2, 16'h1322, 0, 0, 0);
    go(16'h1320);
    put(16'h1500, '{8'h92, 8'h05, 8'h40, 8'h10});
    ex(M_BREL_I, 16'h0012, 16'h1514, 4, 16'h1504, 0, 0, 0);
    go(16'h1500);
    put(16'h1400, '{8'h91, 8'h40});
    ex(M_INH, 0, 0, 2, 16'h1402, 0, 0, 1);
    go(16'h1400);
    put(16'h1410, '{8'h31});
    ex(M_INH, 0, 0, 0, 0, 0, 1, 0);
    go(16'h1410);
    @(negedge i_core_clk);
    chk("req_after_illegal", 16'h0000, {15'h0000, o_mem_req});
    final_report();
  end
endmodule
`default_nettype wire
